/* elb_pkg.sv */
// package: constants and types for the error log entry builder
package elb_pkg;

  // log page selection and transfer length fields of the command word
  localparam logic [7:0] ELB_LOG_ERROR_INFO = 8'h01;
  localparam int         ELB_SEL_LSB        = 0;
  localparam int         ELB_DWCNT_LSB      = 16;
  localparam int         ELB_DWCNT_MSB      = 27;

  // entry geometry and store depth
  localparam int         ELB_ENTRY_BYTES    = 64;
  localparam int         ELB_ENTRY_DWORDS   = ELB_ENTRY_BYTES / 4;
  localparam int         ELB_DEPTH          = 8;
  localparam logic [3:0] ELB_DEPTH_CNT      = 4'h8;
  localparam int         ELB_PTR_W          = 3;

  // byte offsets of the fields inside one entry
  localparam int ELB_OFS_COUNTER = 0;
  localparam int ELB_OFS_SQID    = 8;
  localparam int ELB_OFS_CID     = 10;
  localparam int ELB_OFS_STATUS  = 12;
  localparam int ELB_OFS_PARAM   = 14;
  localparam int ELB_OFS_LBA     = 16;
  localparam int ELB_OFS_NSID    = 24;
  localparam int ELB_OFS_VENDOR  = 28;

  // parameter location: bits 15:11 are reserved
  localparam logic [15:0] ELB_PARAM_MASK = 16'h07ff;
  localparam logic [7:0]  ELB_VENDOR_MIN = 8'h80;

  // register byte addresses on the control bus
  localparam logic [7:0] ELB_REG_CTRL    = 8'h00;
  localparam logic [7:0] ELB_REG_STATUS  = 8'h04;
  localparam logic [7:0] ELB_REG_MASK    = 8'h08;
  localparam logic [7:0] ELB_REG_FILL    = 8'h0c;
  localparam logic [7:0] ELB_REG_CNT_LO  = 8'h10;
  localparam logic [7:0] ELB_REG_CNT_HI  = 8'h14;

  // control bits, interrupt bits and reset values
  localparam int         ELB_CTRL_EN_BIT  = 0;
  localparam int         ELB_CTRL_CLR_BIT = 1;
  localparam logic       ELB_CTRL_EN_RST  = 1'b1;
  localparam int         ELB_IRQ_LOGGED   = 0;
  localparam int         ELB_IRQ_DONE     = 1;
  localparam int         ELB_IRQ_BADSEL   = 2;
  localparam logic [2:0] ELB_MASK_RST     = 3'h0;
  localparam logic [1:0] ELB_RESP_OKAY    = 2'h0;
  localparam logic [1:0] ELB_RESP_SLVERR  = 2'h2;

  // one stored error record
  typedef struct packed {
    logic [63:0] counter;
    logic [15:0] sqid;
    logic [15:0] cid;
    logic [14:0] status;
    logic        phase;
    logic [15:0] param;
    logic [63:0] lba;
    logic [31:0] nsid;
    logic [7:0]  vendor;
  } elb_entry_type;

  // readout sequencer states
  typedef enum logic [1:0] {
    ELB_IDLE = 2'b00,
    ELB_LOAD = 2'b01,
    ELB_SHOW = 2'b10
  } elb_rd_state_type;

endpackage

/* elb_store_if.sv */
// interface: builder to entry store connection
`timescale 1ns/10ps
`default_nettype none
interface elb_store_if
  import elb_pkg::*;
  ();
  logic                 wr_en;
  elb_entry_type        wr_entry;
  logic                 clear;
  logic [ELB_PTR_W-1:0] rd_idx;
  elb_entry_type        rd_entry;
  logic [ELB_PTR_W-1:0] wr_ptr;
  logic [3:0]           count;

  modport master (output wr_en, output wr_entry, output clear,
                  output rd_idx, input rd_entry, input wr_ptr,
                  input count);
  modport store  (input wr_en, input wr_entry, input clear,
                  input rd_idx, output rd_entry, output wr_ptr,
                  output count);
endinterface
`default_nettype wire

/* elb_log_store.sv */
// module: circular store holding the most recent error records
`timescale 1ns/10ps
`default_nettype none
module elb_log_store
  import elb_pkg::*;
  (
  input wire logic   clk,
  input wire logic   rst_n,
  elb_store_if.store sif
  );

  typedef struct packed {
    logic [ELB_PTR_W-1:0] wr_ptr;
    logic [3:0]           count;
  } elb_store_state_type;

  elb_store_state_type r_reg;
  elb_store_state_type r_next;
  elb_entry_type       mem [ELB_DEPTH];

  // pointer wraps, so a full store overwrites its oldest record
  always_comb
  begin
    r_next = r_reg;
    if (sif.clear)
    begin
      r_next.count = 4'h0;
    end
    else if (sif.wr_en)
    begin
      r_next.wr_ptr = r_reg.wr_ptr + 3'h1;
      if (r_reg.count != ELB_DEPTH_CNT)
      begin
        r_next.count = r_reg.count + 4'h1; // depth caps the fill
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // records need no reset: the fill count hides stale slots
  always_ff @(posedge clk)
  begin
    if (sif.wr_en && !sif.clear)
    begin
      mem[r_reg.wr_ptr] <= sif.wr_entry;
    end
  end

  assign sif.rd_entry = mem[sif.rd_idx];
  assign sif.wr_ptr   = r_reg.wr_ptr;
  assign sif.count    = r_reg.count;

endmodule // elb_log_store
`default_nettype wire

/* elb_error_log.sv */
// module: device-wide error information log with register slave
// Notes on behaviour
// - selector 01h returns the error information log
// - log errors flagged more-info or async error
// - one log shared by the whole device
// - n-entry transfer returns the n newest errors
// - newest error first, older ones follow
// - entries are 64 bytes; depth is advertised
// - bytes 7:0 carry the error counter
// - bytes 9:8 carry submission queue identifier
// - bytes 11:10 carry the command identifier
// - bytes 13:12 carry status and phase tag
// - bytes 15:14 locate the faulty parameter
// - bytes 23:16 carry the failing block address
// - bytes 27:24 carry the namespace identifier
// - byte 28 names vendor page, zero none
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module elb_error_log
  import elb_pkg::*;
  (
  input wire logic         SYS_CLK,
  input wire logic         NRST,
  input wire logic         ERR_VALID,
  input wire logic         ERR_MORE,
  input wire logic         ERR_ASYNC,
  input wire logic [15:0]  ERR_SQID,
  input wire logic [15:0]  ERR_CID,
  input wire logic [14:0]  ERR_STATUS,
  input wire logic         ERR_PHASE,
  input wire logic [15:0]  ERR_PARAM,
  input wire logic [63:0]  ERR_LBA,
  input wire logic [31:0]  ERR_NSID,
  input wire logic [7:0]   ERR_VENDOR,
  input wire logic         CMD_VALID,
  output logic             CMD_READY,
  input wire logic [31:0]  CMD_DW10,
  output logic [31:0]      LOG_DATA,
  output logic             LOG_VALID,
  input wire logic         LOG_READY,
  output logic             LOG_DONE,
  output logic             LOG_BAD,
  output logic             IRQ,
  input wire logic [7:0]   AWADDR,
  input wire logic         AWVALID,
  output logic             AWREADY,
  input wire logic [31:0]  WDATA,
  input wire logic [3:0]   WSTRB,
  input wire logic         WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input wire logic         BREADY,
  input wire logic [7:0]   ARADDR,
  input wire logic         ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input wire logic         RREADY
  );

  typedef struct packed {
    elb_rd_state_type     rd;
    logic                 cmd_ready;
    logic [11:0]          idx;
    logic [11:0]          last;
    logic [ELB_PTR_W-1:0] snap_ptr;
    logic [3:0]           snap_cnt;
    logic [31:0]          snap_lo;
    logic [31:0]          data;
    logic                 valid;
    logic                 done;
    logic                 bad;
    logic [63:0]          err_cnt;
    logic                 enable;
    logic                 clr;
    logic [2:0]           irq_st;
    logic [2:0]           irq_mask;
    logic                 irq;
    logic                 aw_got;
    logic [7:0]           aw_addr;
    logic                 w_got;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } elb_state_type;

  elb_state_type r_reg;
  elb_state_type r_next;
  elb_store_if   sif ();
  logic          log_event;
  logic [7:0]    age;
  logic [511:0]  entry_bits;
  logic [31:0]   word;
  logic [2:0]    evts;
  logic          rd_clear;

  // a single store for the whole device, not per namespace
  elb_log_store u_store (
    .clk   (SYS_CLK),
    .rst_n (NRST),
    .sif   (sif)
  );

  // capture only errors flagged more-info or async error, while logging is enabled
  assign log_event = ERR_VALID && (ERR_MORE || ERR_ASYNC) && r_reg.enable;

  // record fields; bad vendor identifiers fold to zero
  assign sif.wr_en            = log_event;
  assign sif.clear            = r_reg.clr;
  assign sif.wr_entry.counter = r_reg.err_cnt + 64'h1;
  assign sif.wr_entry.sqid    = ERR_SQID;
  assign sif.wr_entry.cid     = ERR_CID;
  assign sif.wr_entry.status  = ERR_STATUS;
  assign sif.wr_entry.phase   = ERR_PHASE;
  assign sif.wr_entry.param   = ERR_PARAM & ELB_PARAM_MASK;
  assign sif.wr_entry.lba     = ERR_LBA;
  assign sif.wr_entry.nsid    = ERR_NSID;
  assign sif.wr_entry.vendor  = (ERR_VENDOR >= ELB_VENDOR_MIN) ?
                                ERR_VENDOR : 8'h00;

  // age counts back from the newest record at command time
  assign age        = r_reg.idx[11:4];
  assign sif.rd_idx = ELB_PTR_W'(r_reg.snap_ptr - 3'h1 - age[2:0]);

  // lay one 64-byte entry out; slots past the fill read all zero
  always_comb
  begin
    entry_bits = '0;
    if (age < {4'h0, r_reg.snap_cnt})
    begin
      entry_bits[ELB_OFS_COUNTER*8 +: 64] = sif.rd_entry.counter;
      entry_bits[ELB_OFS_SQID*8 +: 16]    = sif.rd_entry.sqid;
      entry_bits[ELB_OFS_CID*8 +: 16]     = sif.rd_entry.cid;
      entry_bits[ELB_OFS_STATUS*8 +: 16]  = {sif.rd_entry.status,
                                             sif.rd_entry.phase};
      entry_bits[ELB_OFS_PARAM*8 +: 16]   = sif.rd_entry.param;
      entry_bits[ELB_OFS_LBA*8 +: 64]     = sif.rd_entry.lba;
      entry_bits[ELB_OFS_NSID*8 +: 32]    = sif.rd_entry.nsid;
      entry_bits[ELB_OFS_VENDOR*8 +: 8]   = sif.rd_entry.vendor;
    end
  end

  assign word = entry_bits[r_reg.idx[3:0]*32 +: 32];

  // next-state logic for readout, register bus and interrupts
  always_comb
  begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    r_next.bad  = 1'b0;
    r_next.clr  = 1'b0;
    rd_clear    = 1'b0;
    if (log_event)
    begin
      r_next.err_cnt = r_reg.err_cnt + 64'h1;
    end

    // readout: one bubble per dword keeps the store read registered
    case (r_reg.rd)
      ELB_IDLE:
      begin
        if (CMD_VALID && r_reg.cmd_ready)
        begin
          r_next.cmd_ready = 1'b0;
          if (CMD_DW10[ELB_SEL_LSB +: 8] == ELB_LOG_ERROR_INFO)
          begin
            r_next.rd       = ELB_LOAD;
            r_next.idx      = 12'h000;
            r_next.last     = CMD_DW10[ELB_DWCNT_MSB:ELB_DWCNT_LSB];
            r_next.snap_ptr = sif.wr_ptr;
            r_next.snap_cnt = sif.count;
            r_next.snap_lo  = r_reg.err_cnt[31:0];
          end
          else
          begin
            r_next.done      = 1'b1;
            r_next.bad       = 1'b1;
            r_next.cmd_ready = 1'b1;
          end
        end
      end
      ELB_LOAD:
      begin
        r_next.data  = word;
        r_next.valid = 1'b1;
        r_next.rd    = ELB_SHOW;
      end
      ELB_SHOW:
      begin
        if (LOG_READY)
        begin
          r_next.valid = 1'b0;
          if (r_reg.idx == r_reg.last) // count is zero based
          begin
            r_next.done      = 1'b1;
            r_next.cmd_ready = 1'b1;
            r_next.rd        = ELB_IDLE;
          end
          else
          begin
            r_next.idx = r_reg.idx + 12'h001;
            r_next.rd  = ELB_LOAD;
          end
        end
      end
      default:
      begin
        r_next.rd = ELB_IDLE;
      end
    endcase

    // write channel: address and data may arrive in either order
    if (AWVALID && r_reg.awready)
    begin
      r_next.aw_got  = 1'b1;
      r_next.aw_addr = AWADDR;
    end
    if (WVALID && r_reg.wready)
    begin
      r_next.w_got  = 1'b1;
      r_next.w_data = WDATA;
      r_next.w_strb = WSTRB;
    end
    if (r_reg.bvalid && BREADY)
    begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid)
    begin
      r_next.aw_got = 1'b0;
      r_next.w_got  = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = ELB_RESP_OKAY;
      case ({r_reg.aw_addr[7:2], 2'b00})
        ELB_REG_CTRL:
        begin
          if (r_reg.w_strb[0])
          begin
            r_next.enable = r_reg.w_data[ELB_CTRL_EN_BIT];
            r_next.clr    = r_reg.w_data[ELB_CTRL_CLR_BIT];
          end
        end
        ELB_REG_MASK:
        begin
          if (r_reg.w_strb[0])
          begin
            r_next.irq_mask = r_reg.w_data[2:0];
          end
        end
        ELB_REG_STATUS, ELB_REG_FILL, ELB_REG_CNT_LO, ELB_REG_CNT_HI:
        begin
          r_next.bresp = ELB_RESP_OKAY;
        end
        default:
        begin
          r_next.bresp = ELB_RESP_SLVERR;
        end
      endcase
    end

    // read channel: answer one cycle after the address is taken
    if (r_reg.rvalid && RREADY)
    begin
      r_next.rvalid = 1'b0;
    end
    if (ARVALID && r_reg.arready)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = ELB_RESP_OKAY;
      r_next.rdata  = 32'h0;
      case ({ARADDR[7:2], 2'b00})
        ELB_REG_CTRL:   r_next.rdata[0] = r_reg.enable;
        ELB_REG_STATUS:
        begin
          r_next.rdata[2:0] = r_reg.irq_st;
          rd_clear          = 1'b1;
        end
        ELB_REG_MASK:   r_next.rdata[2:0] = r_reg.irq_mask;
        ELB_REG_FILL:   r_next.rdata = {20'h0, ELB_DEPTH_CNT,
                                        4'h0, sif.count};
        ELB_REG_CNT_LO: r_next.rdata = r_reg.err_cnt[31:0];
        ELB_REG_CNT_HI: r_next.rdata = r_reg.err_cnt[63:32];
        default:        r_next.rresp = ELB_RESP_SLVERR;
      endcase
    end

    // sticky status: an event in the clearing read's cycle survives
    evts[ELB_IRQ_LOGGED] = log_event;
    evts[ELB_IRQ_DONE]   = r_next.done && !r_next.bad;
    evts[ELB_IRQ_BADSEL] = r_next.bad;
    r_next.irq_st = (rd_clear ? 3'h0 : r_reg.irq_st) | evts;
    r_next.irq    = |(r_next.irq_st & r_next.irq_mask);

    // ready flags come from flops, so derive them from next state
    r_next.awready = !r_next.aw_got && !r_next.bvalid;
    r_next.wready  = !r_next.w_got && !r_next.bvalid;
    r_next.arready = !r_next.rvalid;
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      r_reg           <= '0;
      r_reg.rd        <= ELB_IDLE;
      r_reg.cmd_ready <= 1'b1;
      r_reg.enable    <= ELB_CTRL_EN_RST;
      r_reg.irq_mask  <= ELB_MASK_RST;
      r_reg.awready   <= 1'b1;
      r_reg.wready    <= 1'b1;
      r_reg.arready   <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign CMD_READY = r_reg.cmd_ready;
  assign LOG_DATA  = r_reg.data;
  assign LOG_VALID = r_reg.valid;
  assign LOG_DONE  = r_reg.done;
  assign LOG_BAD   = r_reg.bad;
  assign IRQ       = r_reg.irq;
  assign AWREADY   = r_reg.awready;
  assign WREADY    = r_reg.wready;
  assign BRESP     = r_reg.bresp;
  assign BVALID    = r_reg.bvalid;
  assign ARREADY   = r_reg.arready;
  assign RDATA     = r_reg.rdata;
  assign RRESP     = r_reg.rresp;
  assign RVALID    = r_reg.rvalid;

  // checks on the readout and capture paths
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  sequence take_s;
    CMD_VALID && CMD_READY;
  endsequence
  sequence take_log_s;
    take_s ##0 (CMD_DW10[7:0] == ELB_LOG_ERROR_INFO);
  endsequence
  sequence last_beat_s;
    LOG_VALID && LOG_READY && (r_reg.idx == r_reg.last);
  endsequence

  log_start_a: assert property (take_log_s |-> ##2 LOG_VALID)
    else $error("log readout did not start two cycles after command");
  bad_select_a: assert property
    (take_s ##0 (CMD_DW10[7:0] != ELB_LOG_ERROR_INFO)
     |=> LOG_DONE && LOG_BAD)
    else $error("unsupported selector not refused");
  capture_gate_a: assert property
    (ERR_VALID && !ERR_MORE && !ERR_ASYNC |=> $stable(r_reg.err_cnt))
    else $error("error without details was logged");
  count_step_a: assert property
    (log_event |=> r_reg.err_cnt == $past(r_reg.err_cnt) + 64'h1)
    else $error("error counter did not step by one");
  depth_cap_a: assert property (sif.count <= ELB_DEPTH_CNT)
    else $error("store fill exceeds depth");
  newest_first_a: assert property
    (LOG_VALID && r_reg.idx == 12'h000 && r_reg.snap_cnt != 4'h0
     |-> LOG_DATA == r_reg.snap_lo)
    else $error("first entry is not the newest error");
  unused_zero_a: assert property
    (LOG_VALID && ({4'h0, r_reg.snap_cnt} <= r_reg.idx[11:4])
     |-> LOG_DATA == 32'h0)
    else $error("unused slot not zero");
  tail_zero_a: assert property
    (LOG_VALID && r_reg.idx[3:0] >= 4'h8 |-> LOG_DATA == 32'h0)
    else $error("entry tail bytes not zero");
  param_rsvd_a: assert property
    (LOG_VALID && r_reg.idx[3:0] == 4'h3 |-> LOG_DATA[31:27] == 5'h0)
    else $error("parameter location reserved bits set");
  vendor_range_a: assert property
    (LOG_VALID && r_reg.idx[3:0] == 4'h7 && LOG_DATA[7:0] != 8'h00
     |-> LOG_DATA[7])
    else $error("vendor page identifier out of range");
  length_end_a: assert property
    (last_beat_s |=> LOG_DONE && !LOG_BAD ##1 CMD_READY)
    else $error("transfer did not end at requested length");

endmodule // elb_error_log
`default_nettype wire

/* elb_host_model.sv */
// partner model: host software fetching log pages
`timescale 1ns/10ps
`default_nettype none
module elb_host_model
  import elb_pkg::*;
  (
  input wire logic        clk,
  input wire logic        cmd_ready,
  input wire logic [31:0] log_data,
  input wire logic        log_valid,
  input wire logic        log_done,
  input wire logic        log_bad,
  output logic            cmd_valid,
  output logic [31:0]     cmd_dw10,
  output logic            log_ready
  );
  logic [31:0] got_q[$];
  logic        bad_seen;
  logic [31:0] lcg = 32'h1d;

  // idle host: no request, not accepting
  initial
  begin
    cmd_valid = 1'b0;
    cmd_dw10  = 32'h0;
    log_ready = 1'b0;
  end

  // one request; stall makes the host drop ready at random
  task automatic fetch(input logic [7:0] sel, input int n_dw,
                       input bit stall);
    int t;
    got_q.delete();
    bad_seen = 1'b0;
    t = 0;
    cmd_dw10  <= {4'h0, 12'(n_dw - 1), 8'h0, sel};
    cmd_valid <= 1'b1;
    log_ready <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
      if (cmd_ready) cmd_valid <= 1'b0;
      if (log_valid && log_ready) got_q.push_back(log_data);
      if (log_done) bad_seen = log_bad;
      lcg = lcg * 32'h41c64e6d + 32'h3039;
      // ready drops on the last pass, so it is written once per edge
      if (log_done || t >= 5000)
        log_ready <= 1'b0;
      else
        log_ready <= !stall || lcg[20];
    end
    while (!log_done && t < 5000);
    @(posedge clk); // one idle edge before the next request
  endtask
endmodule // elb_host_model
`default_nettype wire

/* error_log_entry_builder_tb.sv */
// testbench: error log with host partner and reference queue
`timescale 1ns/10ps
`default_nettype none
module error_log_entry_builder_tb
  import elb_pkg::*;
  ;
  logic        SYS_CLK, NRST, ERR_VALID, ERR_MORE, ERR_ASYNC, ERR_PHASE;
  logic [15:0] ERR_SQID, ERR_CID, ERR_PARAM;
  logic [14:0] ERR_STATUS;
  logic [63:0] ERR_LBA, cnt;
  logic [31:0] ERR_NSID, CMD_DW10, LOG_DATA, WDATA, RDATA;
  logic [7:0]  ERR_VENDOR, AWADDR, ARADDR;
  logic        CMD_VALID, CMD_READY, LOG_VALID, LOG_READY, LOG_DONE;
  logic        LOG_BAD, IRQ, AWVALID, AWREADY, WVALID, WREADY, BVALID;
  logic        BREADY, ARVALID, ARREADY, RVALID, RREADY, en;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic [2:0]  st;
  logic [31:0] seed = 32'h5aca;
  logic [7:0]  bsel[4] = '{8'h00, 8'h02, 8'h03, 8'h80};
  elb_entry_type mq[$];
  int          n_errors = 0;
  int          cmp_count = 0;

  elb_error_log dut_u (.SYS_CLK, .NRST, .ERR_VALID, .ERR_MORE,
    .ERR_ASYNC, .ERR_SQID, .ERR_CID, .ERR_STATUS, .ERR_PHASE,
    .ERR_PARAM, .ERR_LBA, .ERR_NSID, .ERR_VENDOR, .CMD_VALID,
    .CMD_READY, .CMD_DW10, .LOG_DATA, .LOG_VALID, .LOG_READY,
    .LOG_DONE, .LOG_BAD, .IRQ, .AWADDR, .AWVALID, .AWREADY, .WDATA,
    .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
    .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);

  elb_host_model host_u (.clk(SYS_CLK), .cmd_ready(CMD_READY),
    .log_data(LOG_DATA), .log_valid(LOG_VALID), .log_done(LOG_DONE),
    .log_bad(LOG_BAD), .cmd_valid(CMD_VALID), .cmd_dw10(CMD_DW10),
    .log_ready(LOG_READY));

  // 50 MHz clock
  always #10 SYS_CLK = ~SYS_CLK;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // fill register: depth is fixed, count saturates at depth
  function automatic logic [31:0] fill_exp();
    return {20'h0, ELB_DEPTH_CNT, 4'h0, 4'(mq.size())};
  endfunction

  // dword k of the page: entry k/16 counted from the newest
  function automatic logic [31:0] exp_dw(int k);
    elb_entry_type e;
    if (k / 16 >= mq.size()) return 32'h0;
    e = mq[mq.size() - 1 - k / 16];
    case (k % 16)
      0: return e.counter[31:0];
      1: return e.counter[63:32];
      2: return {e.cid, e.sqid};
      3: return {e.param, e.status, e.phase};
      4: return e.lba[31:0];
      5: return e.lba[63:32];
      6: return e.nsid;
      7: return {24'h0, e.vendor};
      default: return 32'h0;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [63:0] exp,
                     input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] rexp);
    int t;
    t = 0;
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do
    begin
      @(posedge SYS_CLK);
      t++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end
    while (!BVALID && t < 100);
    BREADY <= 1'b0;
    chk("write answer", 1'b1, BVALID);
    chk("write resp", rexp, BRESP);
    @(posedge SYS_CLK); // ready is not raised again in this step
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] rexp);
    int t;
    t = 0;
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do
    begin
      @(posedge SYS_CLK);
      t++;
      if (ARREADY) ARVALID <= 1'b0;
    end
    while (!RVALID && t < 100);
    RREADY <= 1'b0;
    chk("read answer", 1'b1, RVALID);
    chk("read resp", rexp, RRESP);
    if (rexp == ELB_RESP_OKAY) chk("read data", exp, RDATA);
    @(posedge SYS_CLK); // ready is not raised again in this step
  endtask

  // back-to-back random errors; about a quarter carry no flag
  task automatic inject(input int n);
    logic [255:0]  r;
    elb_entry_type e;
    for (int i = 0; i < n; i++)
    begin
      r = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      e = r[231:0];
      ERR_VALID  <= 1'b1;
      ERR_MORE   <= r[254];
      ERR_ASYNC  <= r[255];
      ERR_SQID   <= e.sqid;
      ERR_CID    <= e.cid;
      ERR_STATUS <= e.status;
      ERR_PHASE  <= e.phase;
      ERR_PARAM  <= e.param;
      ERR_LBA    <= e.lba;
      ERR_NSID   <= e.nsid;
      ERR_VENDOR <= e.vendor;
      @(posedge SYS_CLK);
      if (en && r[255:254] != 2'h0)
      begin
        cnt++;
        e.counter = cnt;
        e.param &= ELB_PARAM_MASK;
        if (e.vendor < ELB_VENDOR_MIN) e.vendor = 8'h0;
        mq.push_back(e);
        if (mq.size() > ELB_DEPTH) void'(mq.pop_front());
        st[0] = 1'b1;
      end
    end
    ERR_VALID <= 1'b0;
  endtask

  task automatic get_log(input int n_ent, input bit stall);
    host_u.fetch(ELB_LOG_ERROR_INFO, n_ent * 16, stall);
    chk("good flag", 1'b0, host_u.bad_seen);
    chk("dword count", n_ent * 16, host_u.got_q.size());
    for (int k = 0; k < host_u.got_q.size(); k++)
      chk("log dword", exp_dw(k), host_u.got_q[k]);
    st[1] = 1'b1;
  endtask

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  initial
  begin
    #400000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    SYS_CLK = 1'b0;
    NRST = 1'b0;
    {ERR_VALID, ERR_MORE, ERR_ASYNC, ERR_SQID, ERR_CID, ERR_STATUS,
     ERR_PHASE, ERR_PARAM, ERR_LBA, ERR_NSID, ERR_VENDOR} = '0;
    {AWADDR, AWVALID, WDATA, WVALID, BREADY, ARADDR, ARVALID} = '0;
    RREADY = 1'b0;
    WSTRB = 4'hf;
    cnt = 64'h0;
    st = 3'h0;
    en = 1'b1;
    repeat (10) @(posedge SYS_CLK);
    NRST <= 1'b1;
    @(posedge SYS_CLK);
    // reset values, unmapped places and a read-only write
    rd_chk(ELB_REG_CTRL, 32'h1, ELB_RESP_OKAY);
    rd_chk(ELB_REG_MASK, 32'h0, ELB_RESP_OKAY);
    rd_chk(ELB_REG_FILL, fill_exp(), ELB_RESP_OKAY);
    rd_chk(8'h20, 32'h0, ELB_RESP_SLVERR);
    axi_wr(8'h24, 32'h1, ELB_RESP_SLVERR);
    axi_wr(ELB_REG_FILL, 32'h0, ELB_RESP_OKAY);
    rd_chk(ELB_REG_FILL, fill_exp(), ELB_RESP_OKAY);
    // a write without its low byte strobe leaves the mask alone
    WSTRB <= 4'he;
    axi_wr(ELB_REG_MASK, 32'h7, ELB_RESP_OKAY);
    WSTRB <= 4'hf;
    rd_chk(ELB_REG_MASK, 32'h0, ELB_RESP_OKAY);
    end_test("registers");
    // overflow the store; interrupt masked, raised, then cleared
    inject(12);
    chk("irq masked", 1'b0, IRQ);
    rd_chk(ELB_REG_FILL, fill_exp(), ELB_RESP_OKAY);
    axi_wr(ELB_REG_MASK, 32'h7, ELB_RESP_OKAY);
    repeat (2) @(posedge SYS_CLK);
    chk("irq raised", st != 3'h0, IRQ);
    rd_chk(ELB_REG_STATUS, {29'h0, st}, ELB_RESP_OKAY);
    st = 3'h0;
    repeat (2) @(posedge SYS_CLK);
    chk("irq cleared", 1'b0, IRQ);
    end_test("interrupt");
    // partial page with a stalling host, then beyond the stored count
    get_log(3, 1'b1);
    get_log(ELB_DEPTH + 1, 1'b0);
    rd_chk(ELB_REG_CNT_LO, cnt[31:0], ELB_RESP_OKAY);
    rd_chk(ELB_REG_CNT_HI, cnt[63:32], ELB_RESP_OKAY);
    end_test("readout");
    // any other page selector yields no data
    foreach (bsel[i])
    begin
      host_u.fetch(bsel[i], 16, 1'b0);
      chk("bad flag", 1'b1, host_u.bad_seen);
      chk("bad data", 0, host_u.got_q.size());
    end
    st[2] = 1'b1;
    rd_chk(ELB_REG_STATUS, {29'h0, st}, ELB_RESP_OKAY);
    st = 3'h0;
    end_test("selector");
    // disabled logging is ignored; a clear keeps the counter running
    axi_wr(ELB_REG_CTRL, 32'h0, ELB_RESP_OKAY);
    en = 1'b0;
    inject(4);
    rd_chk(ELB_REG_CNT_LO, cnt[31:0], ELB_RESP_OKAY);
    axi_wr(ELB_REG_CTRL, 32'h3, ELB_RESP_OKAY);
    en = 1'b1;
    mq.delete();
    get_log(1, 1'b0);
    inject(3);
    get_log(2, 1'b1);
    rd_chk(ELB_REG_CTRL, 32'h1, ELB_RESP_OKAY);
    end_test("clear");
    report_and_stop();
  end
endmodule // error_log_entry_builder_tb
`default_nettype wire
